// file: cws_cpu_wait.sv
// Operation
// - STOP to NORMAL, select 1: long wait
// - STOP to SLOW, select 1: short wait
// - Idle to NORMAL, select 0: long wait
// - Idle to SLOW, select 0: short wait
// - Reset wait halts peripherals; others do not
// - Requests still latch during a stall
// - No service start while stalled
`timescale 1ns/100ps
`default_nettype none
`include "cws_defines.svh"
module cws_cpu_wait
  import cws_pkg::*;
#(
  parameter int NUM_IRQ = 16,
  parameter int IDX_W = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wake_from_stop,
  input wire logic wake_from_idle,
  input wire logic target_slow,
  input wire logic flash_pwdn_sel,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic interrupt_master_enable,
  output logic cpu_halt,
  output logic periph_halt,
  output logic [NUM_IRQ-1:0] interrupt_latch,
  output logic service_start,
  output logic [IDX_W-1:0] service_vec
);
  cws_cnt_if cif ();
  cws_state_e state_ff;
  cws_state_e nxt_state;
  logic qualify;
  logic nxt_service;
  logic [NUM_IRQ-1:0] latch_ff;
  logic service_ff;
  logic [IDX_W-1:0] vec_ff;

  // All checks in this block run on the one clock and sleep in reset.
  default clocking cws_cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  function automatic logic [`CWS_CNT_W-1:0] wait_len(input logic slow);
    wait_len = slow ? `CWS_SHORT_WAIT : `CWS_LONG_WAIT;
  endfunction

  function automatic logic [IDX_W-1:0] first_set(
    input logic [NUM_IRQ-1:0] v);
    first_set = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = IDX_W'(i);
      end
    end
  endfunction

  cws_wait_counter u_cnt (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .cif(cif)
  );

  // Only the pairing of wake source and select bit starts a wait; the
  // other pairings resume at once.
  assign qualify = (wake_from_stop & flash_pwdn_sel)
                 | (wake_from_idle & ~flash_pwdn_sel);
  // Gating on the counter rather than the state lets a wake be taken in
  // the first cycle after a stall, so back-to-back wakes are not lost.
  assign cif.start = qualify & ~cif.busy;
  assign cif.limit = wait_len(target_slow);

  assign cpu_halt = cif.busy;
  assign periph_halt = cif.busy & (state_ff == CWS_WAIT_RST);
  assign interrupt_latch = latch_ff;
  assign service_start = service_ff;
  assign service_vec = vec_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CWS_RUN: begin
        if (cif.start) begin
          nxt_state = CWS_WAIT_WAKE;
        end
      end
      CWS_WAIT_RST, CWS_WAIT_WAKE: begin
        if (cif.start) begin
          nxt_state = CWS_WAIT_WAKE;
        end else if (!cif.busy) begin
          nxt_state = CWS_RUN;
        end
      end
      default: nxt_state = CWS_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= CWS_WAIT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // A new request wins over the clear from a service start.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= '0;
    end else begin
      latch_ff <= (latch_ff & ~(NUM_IRQ'(service_ff) << vec_ff))
                | irq_req;
    end
  end

  // Blocking on qualify keeps a service from racing a wait that starts in
  // the same cycle.
  assign nxt_service = ~cif.busy & ~qualify & ~service_ff
                     & interrupt_master_enable & (|latch_ff);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      service_ff <= 1'b0;
      vec_ff <= '0;
    end else begin
      service_ff <= nxt_service;
      if (nxt_service) begin
        vec_ff <= first_set(latch_ff);
      end
    end
  end

  // Shadow timing for the checks below: the stall is measured here,
  // independently of the counter's own down-count.
  logic [`CWS_CNT_W-1:0] halt_run_ff;
  logic [`CWS_CNT_W-1:0] exp_len_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_run_ff <= '0;
      exp_len_ff <= `CWS_LONG_WAIT;
    end else begin
      halt_run_ff <= cpu_halt ? halt_run_ff + `CWS_CNT_W'(1) : '0;
      if (cif.start) begin
        exp_len_ff <= cif.limit;
      end
    end
  end

  // Wait lengths, timed by the shadow counter above.
  a_long_wait_len: assert property (
    $fell(cpu_halt) && exp_len_ff == `CWS_LONG_WAIT
      |-> halt_run_ff == `CWS_LONG_WAIT)
    else $error("long wait has wrong length");
  a_short_wait_len: assert property (
    $fell(cpu_halt) && exp_len_ff == `CWS_SHORT_WAIT
      |-> halt_run_ff == `CWS_SHORT_WAIT)
    else $error("short wait has wrong length");
  a_halt_max_len: assert property (
    halt_run_ff <= `CWS_LONG_WAIT)
    else $error("stall ran past the long wait");
  a_slow_picks_short: assert property (
    qualify && !cpu_halt && target_slow
      |=> cpu_halt && exp_len_ff == `CWS_SHORT_WAIT)
    else $error("slow target did not start short wait");
  a_normal_picks_long: assert property (
    qualify && !cpu_halt && !target_slow
      |=> cpu_halt && exp_len_ff == `CWS_LONG_WAIT)
    else $error("normal target did not start long wait");
  a_unqual_no_halt: assert property (
    !cpu_halt && !qualify |=> !cpu_halt)
    else $error("stall began without a qualifying wake");

  // Peripherals stop only in the post-reset wait.
  a_wake_no_periph: assert property (
    $rose(cpu_halt) |-> !periph_halt)
    else $error("peripherals halted at start of a wake wait");
  a_wake_periph_run: assert property (
    cpu_halt && state_ff == CWS_WAIT_WAKE |-> !periph_halt)
    else $error("peripherals halted in a wake wait");
  a_rst_periph_halt: assert property (
    state_ff == CWS_WAIT_RST && halt_run_ff < `CWS_LONG_WAIT
      |-> periph_halt && cpu_halt)
    else $error("reset wait ended early or left peripherals running");

  // Requests keep latching in a stall; service waits for the CPU.
  a_latch_in_stall: assert property (
    cpu_halt && irq_req != '0
      |=> &(interrupt_latch | ~$past(irq_req)))
    else $error("request lost during stall");
  a_latch_kept: assert property (
    !service_start |=> (interrupt_latch & $past(interrupt_latch))
      == $past(interrupt_latch))
    else $error("latched request dropped without service");
  a_no_service_stall: assert property (
    service_start |-> !cpu_halt && $past(interrupt_master_enable))
    else $error("service began during stall or without enable");
  a_ime_gates_service: assert property (
    !interrupt_master_enable |=> !service_start)
    else $error("service began with master enable low");
  a_halt_blocks_service: assert property (
    cpu_halt |=> !service_start)
    else $error("service began right after a stalled cycle");
  a_service_gap: assert property (
    service_start |=> !service_start)
    else $error("service pulses back to back");
  a_service_marked: assert property (
    service_start |-> interrupt_latch[service_vec])
    else $error("service of a source with no latched request");

  c_reset_wait_end: cover property (
    state_ff == CWS_WAIT_RST ##1 state_ff == CWS_RUN);
  c_long_wake: cover property (
    $fell(cpu_halt) && state_ff == CWS_WAIT_WAKE
      && exp_len_ff == `CWS_LONG_WAIT);
  c_short_wake: cover property (
    $fell(cpu_halt) && exp_len_ff == `CWS_SHORT_WAIT);
  c_back_to_back: cover property (
    $fell(cpu_halt) && qualify);
  c_service_after_wait: cover property (
    $fell(cpu_halt) ##[1:4] service_start);
endmodule
`default_nettype wire

// file: cws_defines.svh
`ifndef CWS_DEFINES_SVH
`define CWS_DEFINES_SVH

// Wait lengths in high-frequency clock periods (2^10 and 2^3).
`define CWS_LONG_EXP 10
`define CWS_SHORT_EXP 3
`define CWS_CNT_W 11
`define CWS_LONG_WAIT 11'h400
`define CWS_SHORT_WAIT 11'h008
`define CWS_CNT_RST 11'h3FF

`endif

// file: cws_pkg.sv
package cws_pkg;
  typedef enum logic [2:0] {
    CWS_RUN = 3'b001,
    CWS_WAIT_RST = 3'b010,
    CWS_WAIT_WAKE = 3'b100
  } cws_state_e;
endpackage

// file: cws_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "cws_defines.svh"
interface cws_cnt_if;
  logic start;
  logic [`CWS_CNT_W-1:0] limit;
  logic busy;
  modport ctl (output start, output limit, input busy);
  modport cnt (input start, input limit, output busy);
endinterface
`default_nettype wire

// file: cws_wait_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "cws_defines.svh"
module cws_wait_counter
  import cws_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  cws_cnt_if.cnt cif
);
  logic [`CWS_CNT_W-1:0] cnt_ff;
  logic busy_ff;

  assign cif.busy = busy_ff;

  // The counter leaves reset already running the post-reset wait.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b1;
      cnt_ff <= `CWS_CNT_RST;
    end else if (!busy_ff && cif.start) begin
      busy_ff <= 1'b1;
      cnt_ff <= cif.limit - `CWS_CNT_W'(1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - `CWS_CNT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// file: cws_cpu_wait_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module cws_cpu_wait_tb;
  import cws_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wake_from_stop = 1'b0;
  logic wake_from_idle = 1'b0;
  logic target_slow = 1'b0;
  logic flash_pwdn_sel = 1'b0;
  logic [15:0] irq_req = 16'h0000;
  logic ime = 1'b0;
  logic cpu_halt;
  logic periph_halt;
  logic [15:0] interrupt_latch;
  logic service_start;
  logic [3:0] service_vec;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int p;

  cws_cpu_wait uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .wake_from_stop(wake_from_stop), .wake_from_idle(wake_from_idle),
    .target_slow(target_slow), .flash_pwdn_sel(flash_pwdn_sel),
    .irq_req(irq_req), .interrupt_master_enable(ime), .cpu_halt(cpu_halt),
    .periph_halt(periph_halt), .interrupt_latch(interrupt_latch),
    .service_start(service_start), .service_vec(service_vec));

  always #20 ref_clk = ~ref_clk;

  // The whole run needs about 4200 cycles; the ceiling leaves margin.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      stop_test();
    end
  end

  always @(negedge ref_clk) begin
    if (arst_n && cpu_halt === 1'b1) `CHK(service_start, 1'b0)
  end

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Counts the cycles of one stall; a wake that is ignored yields zero.
  task count_halt(output int nh, output int ph);
    nh = 0;
    ph = 0;
    for (int k = 0; k < 1100; k++) begin
      if (cpu_halt === 1'b1) begin
        nh++;
        if (periph_halt === 1'b1) ph++;
      end else if (nh > 0) begin
        break;
      end
      @(negedge ref_clk);
    end
  endtask

  task wake(input logic stop, input logic sel, input logic slow);
    @(negedge ref_clk);
    wake_from_stop = stop;
    wake_from_idle = ~stop;
    flash_pwdn_sel = sel;
    target_slow = slow;
    @(negedge ref_clk);
    wake_from_stop = 1'b0;
    wake_from_idle = 1'b0;
  endtask

  task wait_service(input logic [3:0] v);
    for (int k = 0; k < 8 && service_start !== 1'b1; k++) @(negedge ref_clk);
    `CHK(service_start, 1'b1)
    `CHK(service_vec, v)
    @(negedge ref_clk);
    `CHK(interrupt_latch[v], 1'b0)
  endtask

  task test_reset;
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    count_halt(n, p);
    `CHK(n, 1024)
    `CHK(p, 1024)
    $display("test reset wait done");
  endtask

  task test_wakes;
    logic [3:0] stop;
    logic [3:0] slow;
    int exp_len[4];
    stop = 4'h3;
    slow = 4'hA;
    exp_len = '{1024, 8, 1024, 8};
    for (int i = 0; i < 4; i++) begin
      wake(stop[i], stop[i], slow[i]);
      count_halt(n, p);
      `CHK(n, exp_len[i])
      `CHK(p, 0)
    end
    // A wake in the first cycle after a stall ends is taken at once.
    wake_from_idle = 1'b1;
    flash_pwdn_sel = 1'b0;
    target_slow = 1'b1;
    @(negedge ref_clk);
    wake_from_idle = 1'b0;
    count_halt(n, p);
    `CHK(n, 8)
    wake(1'b1, 1'b0, 1'b1);
    repeat (3) @(negedge ref_clk);
    `CHK(cpu_halt, 1'b0)
    $display("test wake table done");
  endtask

  task test_irq;
    ime = 1'b1;
    wake(1'b0, 1'b0, 1'b0);
    @(negedge ref_clk);
    irq_req = 16'h0220;
    // A second qualifying wake inside the stall must not restart it.
    wake_from_idle = 1'b1;
    target_slow = 1'b1;
    @(negedge ref_clk);
    irq_req = 16'h0000;
    wake_from_idle = 1'b0;
    target_slow = 1'b0;
    `CHK(interrupt_latch, 16'h0220)
    `CHK(cpu_halt, 1'b1)
    count_halt(n, p);
    // Two of the 1024 stall cycles passed before the count began.
    `CHK(n, 1022)
    wait_service(4'h5);
    wait_service(4'h9);
    ime = 1'b0;
    irq_req = 16'h0008;
    @(negedge ref_clk);
    irq_req = 16'h0000;
    repeat (4) begin
      @(negedge ref_clk);
      `CHK(service_start, 1'b0)
    end
    `CHK(interrupt_latch, 16'h0008)
    ime = 1'b1;
    wait_service(4'h3);
    $display("test interrupt hold done");
  endtask

  initial begin
    test_reset();
    test_wakes();
    test_irq();
    stop_test();
  end
endmodule
`default_nettype wire
